// [eflc_defines.svh]
// Register indices, field positions and reset values of the flash command controller
// Assumes inclusion by bare name from the controller files
`ifndef EFLC_DEFINES_SVH
`define EFLC_DEFINES_SVH

// ****************************************************************
// Register indices, byte address is four times the index
// ****************************************************************
`define EFLC_IDX_DATA_LO   16'hA020
`define EFLC_IDX_DATA_HI   16'hA021
`define EFLC_IDX_ADDR_LO   16'hA022
`define EFLC_IDX_ADDR_HI   16'hA023
`define EFLC_IDX_HELPER    16'hA024
`define EFLC_IDX_CMD       16'hA025
`define EFLC_IDX_ECC_CFG   16'hA028

// ****************************************************************
// Reset values
// ****************************************************************
`define EFLC_RST_DATA      8'h00
`define EFLC_RST_ADDR      8'h00
`define EFLC_RST_HELPER    8'h00
`define EFLC_RST_CMD       8'h80
`define EFLC_RST_CORR_EN   1'b1

// ****************************************************************
// Field positions
// ****************************************************************
`define EFLC_CMD_OP_MSB    4
`define EFLC_CMD_CYC_LSB   5
`define EFLC_CMD_CYC_MSB   7
`define EFLC_CFG_CORR_EN   0
`define EFLC_CFG_ERR_A     1
`define EFLC_CFG_ERR_B     2
`define EFLC_CFG_FAIL      3
`define EFLC_CFG_BUSY      4

// ****************************************************************
// Command encodings of the five operation select bits
// ****************************************************************
`define EFLC_OP_MAIN_READ  5'h10
`define EFLC_OP_MAIN_ERASE 5'h08
`define EFLC_OP_MAIN_WRITE 5'h04
`define EFLC_OP_INFO_READ  5'h02
`define EFLC_OP_INFO_WRITE 5'h01
`define EFLC_OP_INFO_ERASE 5'h03

`endif

// [eflc_pkg.sv]
// Types and the ECC code function of the flash command controller
// Assumes nothing beyond a SystemVerilog compiler
package eflc_pkg;

    typedef enum logic [1:0] {
        EFLC_OP_READ,
        EFLC_OP_ERASE,
        EFLC_OP_WRITE
    } eflc_op_t;

    typedef enum logic {
        EFLC_ST_IDLE,
        EFLC_ST_BUSY
    } eflc_state_t;

    // Hamming code over one byte plus overall parity, upper bits zero
    function automatic logic [7:0] eflc_ecc_code(input logic [7:0] d);
        logic p1;
        logic p2;
        logic p4;
        logic p8;
        logic pall;
        p1   = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
        p2   = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
        p4   = d[1] ^ d[2] ^ d[3] ^ d[7];
        p8   = d[4] ^ d[5] ^ d[6] ^ d[7];
        pall = (^d) ^ p1 ^ p2 ^ p4 ^ p8;
        return {3'h0, pall, p8, p4, p2, p1};
    endfunction

endpackage

// [eflc_cmd_decode.sv]
// Decoder of the five operation select bits into operation and target
// Assumes a combinational caller that checks valid before use
`timescale 1ns/1ps
`default_nettype none
`include "eflc_defines.svh"

module eflc_cmd_decode
    import eflc_pkg::*;
(
    input  wire logic [4:0] op_select,
    output logic            valid,
    output eflc_op_t        op,
    output logic            info_block
);

    always_comb begin
        valid      = 1'b1;
        op         = EFLC_OP_READ;
        info_block = 1'b0;
        case (op_select)
            `EFLC_OP_MAIN_READ: begin
                op = EFLC_OP_READ;
            end
            `EFLC_OP_MAIN_ERASE: begin
                op = EFLC_OP_ERASE;
            end
            `EFLC_OP_MAIN_WRITE: begin
                op = EFLC_OP_WRITE;
            end
            `EFLC_OP_INFO_READ: begin
                op         = EFLC_OP_READ;
                info_block = 1'b1;
            end
            `EFLC_OP_INFO_WRITE: begin
                op         = EFLC_OP_WRITE;
                info_block = 1'b1;
            end
            `EFLC_OP_INFO_ERASE: begin
                op         = EFLC_OP_ERASE;
                info_block = 1'b1;
            end
            default: begin
                valid = 1'b0;
            end
        endcase
    end

endmodule
`default_nettype wire

// [eflc_ecc_dec.sv]
// Single error correction, double error detection of one stored flash word
// Assumes the word holds the data byte low and its ECC code high
`timescale 1ns/1ps
`default_nettype none

module eflc_ecc_dec
    import eflc_pkg::*;
(
    input  wire logic [15:0] raw_word,
    input  wire logic        corr_en,
    output logic      [15:0] result,
    output logic             err_single,
    output logic             err_double
);

    logic [7:0] calc;
    logic [3:0] syn;
    logic       overall;
    logic [7:0] flip;

    always_comb begin
        calc    = eflc_ecc_code(raw_word[7:0]);
        syn     = calc[3:0] ^ raw_word[11:8];
        overall = (^raw_word[7:0]) ^ (^raw_word[12:8]);
        case (syn)
            4'h3:    flip = 8'h01;
            4'h5:    flip = 8'h02;
            4'h6:    flip = 8'h04;
            4'h7:    flip = 8'h08;
            4'h9:    flip = 8'h10;
            4'hA:    flip = 8'h20;
            4'hB:    flip = 8'h40;
            4'hC:    flip = 8'h80;
            default: flip = 8'h00;
        endcase
        if (corr_en) begin
            err_single = overall;
            err_double = ~overall & (syn != 4'h0);
            // Stored code high, corrected byte low
            result = {raw_word[15:8], raw_word[7:0] ^ (overall ? flip : 8'h00)};
        end else begin
            // Raw contents, no checking
            err_single = 1'b0;
            err_double = 1'b0;
            result     = raw_word;
        end
    end

endmodule
`default_nettype wire

// [eflc_controller.sv]
// Flash command controller: APB register file, command sequencer, ECC read path
// Assumes an APB master on the bus side and a flash array that answers fl_req with fl_ack
//
// What this block does
// - Single set bit selects main read/erase/write
// - Read result: ECC code high, data low
// - Any ECC error on read sets fail
// - Two flags record the ECC error type
// - Correction disabled returns raw flash contents
// - Low data register: read result, write data
// - High data register: read result, write data
// - Write data kept apart from read result
// - Two byte registers form the word address
// - Helper register returns ECC of written byte
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "eflc_defines.svh"

module eflc_controller
    import eflc_pkg::*;
#(
    parameter int ADDR_W = 18
)
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   fl_req,
    output eflc_op_t               fl_op,
    output logic                   fl_info_block,
    output logic      [15:0]       fl_addr,
    output logic      [15:0]       fl_wdata,
    input  wire logic              fl_ack,
    input  wire logic [15:0]       fl_rdata,
    output logic      [2:0]        timing_cycle_sel
);

    // ****************************************************************
    // Register addresses
    // ****************************************************************
    function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
        return ADDR_W'({idx, 2'b00});
    endfunction

    localparam logic [ADDR_W-1:0] A_DATA_LO = byte_addr(`EFLC_IDX_DATA_LO);
    localparam logic [ADDR_W-1:0] A_DATA_HI = byte_addr(`EFLC_IDX_DATA_HI);
    localparam logic [ADDR_W-1:0] A_ADDR_LO = byte_addr(`EFLC_IDX_ADDR_LO);
    localparam logic [ADDR_W-1:0] A_ADDR_HI = byte_addr(`EFLC_IDX_ADDR_HI);
    localparam logic [ADDR_W-1:0] A_HELPER  = byte_addr(`EFLC_IDX_HELPER);
    localparam logic [ADDR_W-1:0] A_CMD     = byte_addr(`EFLC_IDX_CMD);
    localparam logic [ADDR_W-1:0] A_ECC_CFG = byte_addr(`EFLC_IDX_ECC_CFG);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        eflc_state_t st;
        logic [7:0]  wdat_lo;
        logic [7:0]  wdat_hi;
        logic [15:0] rdat;
        logic [7:0]  addr_lo;
        logic [7:0]  addr_hi;
        logic [7:0]  helper;
        logic [2:0]  cyc;
        logic [4:0]  op_bits;
        logic        corr_en;
        logic        err_a;
        logic        err_b;
        logic        fail;
        eflc_op_t    op;
        logic        info;
        logic [15:0] fl_addr;
        logic [15:0] fl_wdata;
        logic [31:0] prdata;
        logic        pslverr;
    } eflc_regs_t;

    eflc_regs_t s_reg;
    eflc_regs_t s_next;

    logic       dec_valid;
    eflc_op_t   dec_op;
    logic       dec_info;
    logic [15:0] rd_result;
    logic       rd_err_single;
    logic       rd_err_double;

    logic       setup;
    logic       wr_acc;
    logic       lane0;
    logic [7:0] wbyte;
    logic       done;
    logic       rd_done;
    logic       start;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    eflc_cmd_decode u_cmd_decode (
        .op_select  (pwdata[`EFLC_CMD_OP_MSB:0]),
        .valid      (dec_valid),
        .op         (dec_op),
        .info_block (dec_info)
    );

    eflc_ecc_dec u_ecc_dec (
        .raw_word   (fl_rdata),
        .corr_en    (s_reg.corr_en),
        .result     (rd_result),
        .err_single (rd_err_single),
        .err_double (rd_err_double)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_next  = s_reg;
        setup   = psel & ~penable;
        wr_acc  = psel & penable & pwrite;
        lane0   = pstrb[0];
        wbyte   = pwdata[7:0];
        done    = (s_reg.st == EFLC_ST_BUSY) & fl_ack;
        rd_done = done & (s_reg.op == EFLC_OP_READ);
        start   = wr_acc & lane0 & (paddr == A_CMD) & dec_valid & (s_reg.st == EFLC_ST_IDLE);

        // Bus writes, low byte lane only
        if (wr_acc && lane0) begin
            case (paddr)
                A_DATA_LO: s_next.wdat_lo = wbyte;
                A_DATA_HI: s_next.wdat_hi = wbyte;
                A_ADDR_LO: s_next.addr_lo = wbyte;
                A_ADDR_HI: s_next.addr_hi = wbyte;
                A_HELPER:  s_next.helper  = wbyte;
                A_CMD: begin
                    s_next.cyc = pwdata[`EFLC_CMD_CYC_MSB:`EFLC_CMD_CYC_LSB];
                end
                A_ECC_CFG: begin
                    s_next.corr_en = pwdata[`EFLC_CFG_CORR_EN];
                    if (pwdata[`EFLC_CFG_ERR_A]) begin
                        s_next.err_a = 1'b0;
                    end
                    if (pwdata[`EFLC_CFG_ERR_B]) begin
                        s_next.err_b = 1'b0;
                    end
                    if (pwdata[`EFLC_CFG_FAIL]) begin
                        s_next.fail = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Command start captures address and write data
        if (start) begin
            s_next.st       = EFLC_ST_BUSY;
            s_next.op_bits  = pwdata[`EFLC_CMD_OP_MSB:0];
            s_next.op       = dec_op;
            s_next.info     = dec_info;
            s_next.fl_addr  = {s_reg.addr_hi, s_reg.addr_lo};
            s_next.fl_wdata = {s_reg.wdat_hi, s_reg.wdat_lo};
        end

        // Completion; hardware set wins over software clear
        if (done) begin
            s_next.st      = EFLC_ST_IDLE;
            s_next.op_bits = 5'h00;
        end
        if (rd_done) begin
            s_next.rdat = rd_result;
            if (rd_err_single) begin
                s_next.err_a = 1'b1;
            end
            if (rd_err_double) begin
                s_next.err_b = 1'b1;
            end
            if (rd_err_single || rd_err_double) begin
                s_next.fail = 1'b1;
            end
        end

        // Read data prepared in setup, presented in access
        if (setup) begin
            s_next.pslverr = 1'b0;
            case (paddr)
                A_DATA_LO: s_next.prdata = {24'h0, s_reg.rdat[7:0]};
                A_DATA_HI: s_next.prdata = {24'h0, s_reg.rdat[15:8]};
                A_ADDR_LO: s_next.prdata = {24'h0, s_reg.addr_lo};
                A_ADDR_HI: s_next.prdata = {24'h0, s_reg.addr_hi};
                A_HELPER:  s_next.prdata = {24'h0, eflc_ecc_code(s_reg.helper)};
                A_CMD:     s_next.prdata = {24'h0, s_reg.cyc, s_reg.op_bits};
                A_ECC_CFG: s_next.prdata = {27'h0,
                                            s_reg.st == EFLC_ST_BUSY,
                                            s_reg.fail,
                                            s_reg.err_b,
                                            s_reg.err_a,
                                            s_reg.corr_en};
                default: begin
                    s_next.prdata  = 32'h0;
                    s_next.pslverr = 1'b1;
                end
            endcase
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_reg.st       <= EFLC_ST_IDLE;
            s_reg.wdat_lo  <= `EFLC_RST_DATA;
            s_reg.wdat_hi  <= `EFLC_RST_DATA;
            s_reg.rdat     <= 16'h0000;
            s_reg.addr_lo  <= `EFLC_RST_ADDR;
            s_reg.addr_hi  <= `EFLC_RST_ADDR;
            s_reg.helper   <= `EFLC_RST_HELPER;
            s_reg.cyc      <= 3'(`EFLC_RST_CMD >> `EFLC_CMD_CYC_LSB);
            s_reg.op_bits  <= 5'(`EFLC_RST_CMD);
            s_reg.corr_en  <= `EFLC_RST_CORR_EN;
            s_reg.err_a    <= 1'b0;
            s_reg.err_b    <= 1'b0;
            s_reg.fail     <= 1'b0;
            s_reg.op       <= EFLC_OP_READ;
            s_reg.info     <= 1'b0;
            s_reg.fl_addr  <= 16'h0000;
            s_reg.fl_wdata <= 16'h0000;
            s_reg.prdata   <= 32'h0000_0000;
            s_reg.pslverr  <= 1'b0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign prdata           = s_reg.prdata;
    assign pready           = 1'b1;
    assign pslverr          = s_reg.pslverr & psel & penable;
    assign fl_req           = s_reg.st == EFLC_ST_BUSY;
    assign fl_op            = s_reg.op;
    assign fl_info_block    = s_reg.info;
    assign fl_addr          = s_reg.fl_addr;
    assign fl_wdata         = s_reg.fl_wdata;
    // Software is expected to program all ones here
    assign timing_cycle_sel = s_reg.cyc;

endmodule
`default_nettype wire

// [eflc_properties.sv]
// Port checker of the flash command controller
// Assumes binding onto every eflc_controller instance
`timescale 1ns/1ps
`default_nettype none
`include "eflc_defines.svh"
module eflc_properties
    import eflc_pkg::*;
#(
    parameter int ADDR_W = 18
)
(
    input wire logic              clk,
    input wire logic              nrst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              fl_req,
    input wire eflc_op_t          fl_op,
    input wire logic              fl_info_block,
    input wire logic [15:0]       fl_addr,
    input wire logic [15:0]       fl_wdata,
    input wire logic              fl_ack,
    input wire logic [15:0]       fl_rdata,
    input wire logic [2:0]        timing_cycle_sel
);
    // ****************
    // Bus, command decode and request checks
    // ****************
    logic [7:0] wd_q;
    logic       wc;
    logic       go;
    assign wc = psel && penable && pwrite && pstrb[0]
        && paddr == ADDR_W'({`EFLC_IDX_CMD, 2'b00});
    assign go = wc && !fl_req
        && (pwdata[4:0] inside {5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h03});
    function automatic eflc_op_t eop(input logic [4:0] c);
        if (c inside {5'h10, 5'h02})
            return EFLC_OP_READ;
        if (c inside {5'h08, 5'h03})
            return EFLC_OP_ERASE;
        return EFLC_OP_WRITE;
    endfunction
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            wd_q <= 8'h00;
        else
            wd_q <= pwdata[7:0];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_apb; pready && (!pslverr || (psel && penable)); endproperty
    a_apb: assert property (p_apb) else $error("Bad ready or error");
    property p_rdz; prdata[31:8] == 24'h0; endproperty
    a_rdz: assert property (p_rdz) else $error("Read data upper bits set");
    property p_start; go |=> fl_req; endproperty
    a_start: assert property (p_start) else $error("Command did not start");
    property p_bad; wc && !fl_req && !go |=> !fl_req; endproperty
    a_bad: assert property (p_bad) else $error("Invalid command started");
    property p_main; go && !pwdata[1] && !pwdata[0] |=> !fl_info_block && fl_op == eop(wd_q[4:0]);
    endproperty
    a_main: assert property (p_main) else $error("Main decode wrong");
    property p_info; go && (pwdata[1] || pwdata[0]) |=> fl_info_block && fl_op == eop(wd_q[4:0]);
    endproperty
    a_info: assert property (p_info) else $error("Info decode wrong");
    property p_cyc; wc |=> timing_cycle_sel == wd_q[7:5]; endproperty
    a_cyc: assert property (p_cyc) else $error("Cycle select not stored");
    property p_hold; fl_req && !fl_ack |=> fl_req && $stable(fl_addr) && $stable(fl_wdata);
    endproperty
    a_hold: assert property (p_hold) else $error("Request not held");
    property p_end; fl_req && fl_ack |=> !fl_req ##1 !fl_req; endproperty
    a_end: assert property (p_end) else $error("Request not ended");
endmodule
bind eflc_controller eflc_properties #(.ADDR_W(ADDR_W)) eflc_properties_inst (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fl_req(fl_req), .fl_op(fl_op), .fl_info_block(fl_info_block),
    .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_ack(fl_ack), .fl_rdata(fl_rdata),
    .timing_cycle_sel(timing_cycle_sel));
`default_nettype wire

// [eflc_flash_model.sv]
// Behavioural flash array answering the controller's requests
// Assumes a level request held until a one-cycle acknowledge
`timescale 1ns/1ps
`default_nettype none
module eflc_flash_model
    import eflc_pkg::*;
#(
    parameter logic [15:0] ERASE_VAL = 16'hFFFF,
    parameter int          SECTOR    = 512
)
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        fl_req,
    input  wire eflc_op_t    fl_op,
    input  wire logic        fl_info_block,
    input  wire logic [15:0] fl_addr,
    input  wire logic [15:0] fl_wdata,
    input  wire logic [2:0]  delay,
    output logic             fl_ack,
    output logic [15:0]      fl_rdata
);
    // ****************
    // Array and answer
    // ****************
    logic [15:0] mem [int];
    logic [2:0]  cnt;
    int          key;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fl_ack <= 1'b0;
            cnt <= 3'h0;
            fl_rdata <= 16'h5A5A;
        end else if (fl_ack || !fl_req) begin
            // Stale data toggles so it never passes as valid
            fl_ack <= 1'b0;
            cnt <= 3'h0;
            fl_rdata <= ~fl_rdata;
        end else if (cnt < delay) begin
            cnt <= cnt + 3'h1;
        end else begin
            fl_ack <= 1'b1;
            key = {fl_info_block, fl_addr};
            if (fl_op == EFLC_OP_READ)
                fl_rdata <= mem.exists(key) ? mem[key] : ERASE_VAL;
            else if (fl_op == EFLC_OP_WRITE)
                mem[key] = fl_wdata;
            else
                foreach (mem[k])
                    if (k / SECTOR == key / SECTOR)
                        mem[k] = ERASE_VAL;
        end
    end
endmodule
`default_nettype wire

// [test_eflash_command_controller.sv]
// Self-checking bench of the flash command controller
// Assumes controller, checker and flash model compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "eflc_defines.svh"
module test_eflash_command_controller;
    import eflc_pkg::*;
    logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [17:0] paddr = 18'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'hF;
    logic [2:0]  dly = 3'h0, tcs;
    logic        pready, pslverr, fl_req, fl_info_block, fl_ack, er, dbl;
    logic        ce = 1'b1, ea = 1'b0, eb = 1'b0, fl = 1'b0;
    logic [15:0] fl_addr, fl_wdata, fl_rdata, lastx, a;
    logic [15:0] mem [int];
    logic [15:0] ridx [7] = '{16'hA020, 16'hA021, 16'hA022, 16'hA023, 16'hA024, 16'hA025,
                              16'hA028};
    logic [7:0]  rrst [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h01};
    logic [7:0]  d;
    eflc_op_t    fl_op;
    int          fails = 0, num_checks = 0, cyc = 0, seed = 32'h7651A58A;
    eflc_controller eflc_controller_inst (
        .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fl_req(fl_req), .fl_op(fl_op), .fl_info_block(fl_info_block),
        .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_ack(fl_ack), .fl_rdata(fl_rdata),
        .timing_cycle_sel(tcs));
    eflc_flash_model eflc_flash_model_inst (
        .clk(clk), .nrst(nrst), .fl_req(fl_req), .fl_op(fl_op), .fl_info_block(fl_info_block),
        .fl_addr(fl_addr), .fl_wdata(fl_wdata), .delay(dly), .fl_ack(fl_ack),
        .fl_rdata(fl_rdata));
    // ****************
    // Helpers
    // ****************
    initial forever #20 clk = ~clk;
    task automatic summarize();
        $display("Checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end
    task automatic chk_reg(input string n, input logic [7:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== {24'h0, e}) begin
            fails++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_link(input string n, input logic [17:0] e, input logic [17:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [7:0] ecc(input logic [7:0] v);
        logic [3:0] p;
        p = {^(v & 8'hF0), ^(v & 8'h8E), ^(v & 8'h6D), ^(v & 8'h5B)};
        return {3'h0, ^v ^ ^p, p};
    endfunction
    task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] v);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, v};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rchk(input string n, input logic [15:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        chk_reg(n, e, rd);
    endtask
    task automatic run(input logic [4:0] c, input logic [15:0] ad, input logic [15:0] wd);
        int         k;
        logic [15:0] raw, x;
        logic [7:0] s;
        k = {c inside {5'h01, 5'h02, 5'h03}, ad};
        dly <= 3'($random(seed));
        apb(1'b1, `EFLC_IDX_ADDR_LO, ad[7:0]);
        apb(1'b1, `EFLC_IDX_ADDR_HI, ad[15:8]);
        apb(1'b1, `EFLC_IDX_DATA_LO, wd[7:0]);
        apb(1'b1, `EFLC_IDX_DATA_HI, wd[15:8]);
        apb(1'b1, `EFLC_IDX_CMD, {3'b111, c});
        chk_link("start", {1'b1, k[16:0]}, {fl_req, fl_info_block, fl_addr});
        chk_link("wdata", {2'b0, wd}, {2'b0, fl_wdata});
        chk_link("op", c inside {5'h10, 5'h02} ? 18'(EFLC_OP_READ) : c inside {5'h08, 5'h03}
            ? 18'(EFLC_OP_ERASE) : 18'(EFLC_OP_WRITE), 18'(fl_op));
        chk_link("cycle sel", 18'h7, 18'(tcs));
        while (fl_req !== 1'b0)
            @(posedge clk);
        if (c inside {5'h04, 5'h01}) begin
            mem[k] = wd;
        end else if (c inside {5'h08, 5'h03}) begin
            foreach (mem[j])
                if (j / 512 == k / 512)
                    mem[j] = 16'hFFFF;
        end else begin
            raw = mem.exists(k) ? mem[k] : 16'hFFFF;
            x = raw;
            s = raw[15:8] ^ ecc(raw[7:0]);
            dbl = 1'b0;
            if (ce && s != 8'h0) begin
                fl = 1'b1;
                for (int b = 0; b < 8; b++)
                    if (ecc(raw[7:0] ^ (8'h1 << b)) == raw[15:8])
                        x[7:0] = raw[7:0] ^ (8'h1 << b);
                dbl = x == raw && $countones(s) != 1;
                ea = ea | !dbl;
                eb = eb | dbl;
            end
            lastx = x;
            if (!dbl) begin
                rchk("data low", `EFLC_IDX_DATA_LO, x[7:0]);
                rchk("data high", `EFLC_IDX_DATA_HI, x[15:8]);
            end
            rchk("ecc cfg", `EFLC_IDX_ECC_CFG, {4'h0, fl, eb, ea, ce});
        end
        rchk("command", `EFLC_IDX_CMD, 8'hE0);
    endtask
    // ****************
    // Main sequence
    // ****************
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk_link("reset cycle sel", 18'h4, 18'(tcs));
        foreach (ridx[i])
            rchk("reset", ridx[i], rrst[i]);
        apb(1'b1, 16'hA026, 8'h55);
        chk_reg("unmapped", 8'h01, {31'h0, er});
        $display("Test reset done");
        repeat (6) begin
            d = 8'($random(seed));
            apb(1'b1, `EFLC_IDX_HELPER, d);
            rchk("helper", `EFLC_IDX_HELPER, ecc(d));
        end
        $display("Test helper done");
        for (int i = 0; i < 8; i++) begin
            d = 8'($random(seed));
            a = 16'($random(seed));
            run(i[0] ? 5'h01 : 5'h04, a, {ecc(d), d ^ (i < 4 ? 8'h00 : i < 6 ? 8'h20 : 8'h82)});
            run(i[0] ? 5'h02 : 5'h10, a, 16'h0);
            apb(1'b1, `EFLC_IDX_DATA_LO, ~lastx[7:0]);
            if (!dbl)
                rchk("read kept", `EFLC_IDX_DATA_LO, lastx[7:0]);
            apb(1'b1, `EFLC_IDX_ECC_CFG, 8'h0F);
            {ea, eb, fl} = 3'b000;
        end
        $display("Test write read done");
        apb(1'b1, `EFLC_IDX_ECC_CFG, 8'h00);
        ce = 1'b0;
        for (int i = 0; i < 2; i++) begin
            a = 16'($random(seed));
            run(i ? 5'h01 : 5'h04, a, 16'h1234);
            run(i ? 5'h03 : 5'h08, a ^ 16'h1, 16'h0);
            run(i ? 5'h02 : 5'h10, a, 16'h0);
        end
        $display("Test erase raw done");
        apb(1'b1, `EFLC_IDX_CMD, 8'hF8);
        chk_link("bad command", 18'h0, {17'h0, fl_req});
        $display("Test invalid done");
        summarize();
    end
endmodule
`default_nettype wire
